// ---- shared/cfg_defines.vh ----
// constants for the power, rom and subsystem configuration block
//
// Operation
// - two-bit power state field reads back present state; writes of a valid code change state
// - code 11 is the deepest state, code 00 keeps everything on
// - deepest state forces io, memory and bus master enables to zero
// - deepest state switches memory bus buffers to the plain low-voltage type
// - deepest state stops pixel clock, converter, palette ram and pixel pll
// - deepest state stops system clock and powers down the core pll
// - power state field updates only on the two valid codes
// - leaving deepest state raises an internal reset for 16 pci clocks
// - capability link field reads fixed 00h
// - capability revision field reads 001b for version 1.0
// - rom enable bit writable when strap set, reads zero otherwise
// - rom base field writable when strap set, reads zero otherwise
// - overlapping apertures decode by fixed priority, boot rom highest
// - an aperture is claimed only if no higher one matches; else no response
// - rom base bits 15 to 1 always read zero
// - subsystem register read at 2Ch, written only through alias 4Ch
// - boot rom strap sampled from a host data line on hard reset
`ifndef CFG_DEFINES_VH
`define CFG_DEFINES_VH
`define OFS_SUBSYS      8'h2C
`define OFS_ROMBASE     8'h30
`define OFS_DEVICE_CONTROL_REG     8'h04
`define OFS_SUBSYS_WR   8'h4C
`define OFS_PMCAP       8'hDC
`define OFS_PMCSR       8'hE0
`define PS_D0           2'h0
`define PS_D3           2'h3
`define PMCAP_VALUE     32'h00210001
`define PMCAP_CODE      8'h01
`define PMCAP_LINK      8'h00
`define PMCAP_REV       3'h1
`define INT_RESET_CYC   5'h10
`define ROM_SMALL_VID   16'h0078
`define ROM_32K_VID     16'h7FF8
`define ROM_64K_VID     16'hFFF8
`define ROM_SEL_SMALL   2'h0
`define ROM_SEL_32K     2'h1
`define ROM_SEL_64K     2'h2
`define BIT_IOSPACE     0
`define BIT_MEMSPACE    1
`define BIT_BUSMASTER   2
`define SPI_DIV         4'h8
`endif

// ---- logic/edge_sync.v ----
// two-flop synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
	input  wire clk,
	input  wire rst_n,
	input  wire din,
	output wire level,
	output wire rise,
	output wire fall
);
	reg meta_q;
	reg sync_q;
	reg last_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end
	assign level = sync_q;
	assign rise  = sync_q & ~last_q;
	assign fall  = ~sync_q & last_q;
endmodule // edge_sync
`default_nettype wire

// ---- logic/rom_word_loader.v ----
// serial boot rom reader fetching the two subsystem words
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defines.vh"
module rom_word_loader (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        start,
	input  wire [1:0]  rom_size_sel,
	input  wire        rom_miso,
	output reg         rom_cs_n,
	output reg         rom_sck,
	output reg         rom_mosi,
	output reg  [31:0] word_out,
	output reg         done
);
	localparam ST_IDLE = 2'h0;
	localparam ST_SHIFT = 2'h1;
	localparam ST_DONE = 2'h2;
	reg [1:0]  st_q;
	reg [3:0]  div_q;
	reg [5:0]  bit_q;
	reg [23:0] cmd_q;
	reg [15:0] addr;
	always @* begin
		case (rom_size_sel)
			`ROM_SEL_32K: addr = `ROM_32K_VID;
			`ROM_SEL_64K: addr = `ROM_64K_VID;
			default:      addr = `ROM_SMALL_VID;
		endcase
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			div_q <= 4'h0;
			bit_q <= 6'h00;
			cmd_q <= 24'h000000;
			rom_cs_n <= 1'b1;
			rom_sck <= 1'b0;
			rom_mosi <= 1'b0;
			word_out <= 32'h00000000;
			done <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (start) begin
						cmd_q <= {8'h03, addr};
						rom_cs_n <= 1'b0;
						bit_q <= 6'h00;
						div_q <= 4'h0;
						st_q <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					div_q <= div_q + 4'h1;
					if (div_q == 4'h0) begin
						rom_mosi <= cmd_q[23];
						rom_sck <= 1'b0;
					end else if (div_q == (`SPI_DIV >> 1)) begin
						rom_sck <= 1'b1;
						if (bit_q >= 6'h18)
							word_out <= {rom_miso, word_out[31:1]};
						cmd_q <= {cmd_q[22:0], 1'b0};
					end else if (div_q == `SPI_DIV - 4'h1) begin
						div_q <= 4'h0;
						bit_q <= bit_q + 6'h01;
						if (bit_q == 6'h37) begin
							st_q <= ST_DONE;
							rom_cs_n <= 1'b1;
							rom_sck <= 1'b0;
						end
					end
				end
				ST_DONE: begin
					done <= 1'b1;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // rom_word_loader
`default_nettype wire

// ---- logic/pci_power_rom_config_regs.v ----
// configuration registers for power state, rom base and subsystem identity
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defines.vh"
module pci_power_rom_config_regs (
	input  wire        sys_clk,
	input  wire        reset_n,
	input  wire        cfg_wr,
	input  wire        cfg_rd,
	input  wire [7:0]  cfg_addr,
	input  wire [3:0]  cfg_be,
	input  wire [31:0] cfg_wdata,
	output reg  [31:0] cfg_rdata,
	output reg         cfg_ack,
	input  wire        mem_req,
	input  wire        hit_rom,
	input  wire        hit_ctrl,
	input  wire        hit_dma,
	input  wire        hit_legacy_fb,
	input  wire        hit_main_fb,
	output reg  [2:0]  aperture_sel,
	output reg         mem_claim,
	input  wire        host_data_strap_line,
	input  wire [1:0]  rom_size_sel,
	input  wire        rom_miso,
	output reg         rom_cs_n,
	output reg         rom_sck,
	output reg         rom_mosi,
	output reg  [2:0]  device_control_reg,
	output reg         mem_buf_sstl,
	output reg         pixel_clk_off,
	output reg         converter_power_on_n,
	output reg         palette_ram_sel,
	output reg         pixel_pll_power_n,
	output reg         sys_clk_off,
	output reg         core_pll_power_n,
	output reg         internal_reset_n,
	output reg         subsys_loaded
);
	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	reg rst_meta_q;
	reg rst_q;
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_q <= rst_meta_q;
		end
	end
	wire rst_n = rst_q;

	// ------------------------------------------------------------
	// strap and rom input synchronisers
	// ------------------------------------------------------------
	wire strap_s;
	wire miso_s;
	edge_sync u_strap (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.din   (host_data_strap_line),
		.level (strap_s),
		.rise  (),
		.fall  ()
	);
	edge_sync u_miso (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.din   (rom_miso),
		.level (miso_s),
		.rise  (),
		.fall  ()
	);

	// ------------------------------------------------------------
	// strap capture after release
	// ------------------------------------------------------------
	reg [2:0] boot_cnt_q;
	reg       rom_strap_q;
	reg       boot_done_q;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_cnt_q <= 3'h0;
			rom_strap_q <= 1'b0;
			boot_done_q <= 1'b0;
		end else if (!boot_done_q) begin
			boot_cnt_q <= boot_cnt_q + 3'h1;
			if (boot_cnt_q == 3'h3) begin
				rom_strap_q <= strap_s;
				boot_done_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// boot rom word load
	// ------------------------------------------------------------
	wire        ld_cs_n;
	wire        ld_sck;
	wire        ld_mosi;
	wire [31:0] ld_word;
	wire        ld_done;
	reg         ld_start_q;
	reg         ld_fired_q;
	// single start pulse once the strap is captured
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ld_start_q <= 1'b0;
			ld_fired_q <= 1'b0;
		end else begin
			ld_start_q <= boot_done_q & ~ld_fired_q;
			ld_fired_q <= ld_fired_q | boot_done_q;
		end
	end
	rom_word_loader u_loader (
		.clk          (sys_clk),
		.rst_n        (rst_n),
		.start        (ld_start_q),
		.rom_size_sel (rom_size_sel),
		.rom_miso     (miso_s),
		.rom_cs_n     (ld_cs_n),
		.rom_sck      (ld_sck),
		.rom_mosi     (ld_mosi),
		.word_out     (ld_word),
		.done         (ld_done)
	);

	// ------------------------------------------------------------
	// power state and internal reset
	// ------------------------------------------------------------
	reg [1:0] pstate_q;
	reg [4:0] irst_cnt_q;
	wire      wr_pm = cfg_wr & (cfg_addr == `OFS_PMCSR) & cfg_be[0];
	wire      ps_valid = (cfg_wdata[1:0] == `PS_D0) | (cfg_wdata[1:0] == `PS_D3);
	wire      leave_d3 = wr_pm & ps_valid & (pstate_q == `PS_D3) &
	                     (cfg_wdata[1:0] == `PS_D0);
	wire      in_d3 = (pstate_q == `PS_D3);
	wire      irst_busy = (irst_cnt_q != 5'h00);
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pstate_q <= `PS_D0;
			irst_cnt_q <= 5'h00;
		end else begin
			if (wr_pm & ps_valid)
				pstate_q <= cfg_wdata[1:0];
			if (leave_d3)
				irst_cnt_q <= `INT_RESET_CYC;
			else if (irst_busy)
				irst_cnt_q <= irst_cnt_q - 5'h01;
		end
	end

	// ------------------------------------------------------------
	// device control, rom base and subsystem registers
	// ------------------------------------------------------------
	reg [2:0]  devctl_q;
	reg        romen_q;
	reg [15:0] rombase_q;
	reg [31:0] subsys_q;
	reg        loaded_q;
	wire       wr_dc = cfg_wr & (cfg_addr == `OFS_DEVICE_CONTROL_REG) & cfg_be[0];
	wire       wr_rb = cfg_wr & (cfg_addr == `OFS_ROMBASE);
	wire       wr_ss = cfg_wr & (cfg_addr == `OFS_SUBSYS_WR);
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			devctl_q <= 3'h0;
			romen_q <= 1'b0;
			rombase_q <= 16'h0000;
			subsys_q <= 32'h00000000;
			loaded_q <= 1'b0;
		end else if (irst_busy) begin
			devctl_q <= 3'h0;
			romen_q <= 1'b0;
			rombase_q <= 16'h0000;
		end else begin
			if (in_d3)
				devctl_q <= 3'h0;
			else if (wr_dc)
				devctl_q <= cfg_wdata[2:0];
			if (wr_rb & rom_strap_q) begin
				if (cfg_be[0])
					romen_q <= cfg_wdata[0];
				if (cfg_be[2])
					rombase_q[7:0] <= cfg_wdata[23:16];
				if (cfg_be[3])
					rombase_q[15:8] <= cfg_wdata[31:24];
			end
			if (ld_done & ~loaded_q) begin
				subsys_q <= ld_word;
				loaded_q <= 1'b1;
			end else if (wr_ss) begin
				if (cfg_be[0])
					subsys_q[7:0] <= cfg_wdata[7:0];
				if (cfg_be[1])
					subsys_q[15:8] <= cfg_wdata[15:8];
				if (cfg_be[2])
					subsys_q[23:16] <= cfg_wdata[23:16];
				if (cfg_be[3])
					subsys_q[31:24] <= cfg_wdata[31:24];
			end
		end
	end

	// ------------------------------------------------------------
	// configuration read path
	// ------------------------------------------------------------
	reg [31:0] rd_d;
	always @* begin
		rd_d = 32'h00000000;
		case (cfg_addr)
			`OFS_DEVICE_CONTROL_REG: rd_d = {29'h0, devctl_q};
			`OFS_SUBSYS:  rd_d = subsys_q;
			`OFS_ROMBASE: rd_d = rom_strap_q ? {rombase_q, 15'h0000, romen_q}
			                                 : 32'h00000000;
			`OFS_PMCAP:   rd_d = `PMCAP_VALUE;
			`OFS_PMCSR:   rd_d = {30'h0, pstate_q};
			default:      rd_d = 32'h00000000;
		endcase
	end

	// ------------------------------------------------------------
	// aperture priority decode
	// ------------------------------------------------------------
	localparam AP_NONE   = 3'h0;
	localparam AP_ROM    = 3'h1;
	localparam AP_CTRL   = 3'h2;
	localparam AP_DMA    = 3'h3;
	localparam AP_LEGACY = 3'h4;
	localparam AP_MAIN   = 3'h5;

	reg [2:0] ap_d;
	reg       claim_d;
	wire      rom_ok = hit_rom & rom_strap_q & romen_q;
	wire      mem_ok = devctl_q[`BIT_MEMSPACE];
	always @* begin
		ap_d = AP_NONE;
		claim_d = 1'b0;
		if (mem_req) begin
			claim_d = 1'b1;
			if (rom_ok)
				ap_d = AP_ROM;
			else if (mem_ok & hit_ctrl)
				ap_d = AP_CTRL;
			else if (mem_ok & hit_dma)
				ap_d = AP_DMA;
			else if (mem_ok & hit_legacy_fb)
				ap_d = AP_LEGACY;
			else if (mem_ok & hit_main_fb)
				ap_d = AP_MAIN;
			else
				claim_d = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// config bus outputs
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata <= 32'h00000000;
			cfg_ack <= 1'b0;
		end else begin
			cfg_rdata <= cfg_rd ? rd_d : 32'h00000000;
			cfg_ack <= cfg_rd | cfg_wr;
		end
	end

	// ------------------------------------------------------------
	// decode outputs
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aperture_sel <= AP_NONE;
			mem_claim <= 1'b0;
		end else begin
			aperture_sel <= ap_d;
			mem_claim <= claim_d;
		end
	end

	// ------------------------------------------------------------
	// serial rom pins
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rom_cs_n <= 1'b1;
			rom_sck <= 1'b0;
			rom_mosi <= 1'b0;
		end else begin
			rom_cs_n <= ld_cs_n;
			rom_sck <= ld_sck;
			rom_mosi <= ld_mosi;
		end
	end

	// ------------------------------------------------------------
	// power-down outputs
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			device_control_reg <= 3'h0;
			mem_buf_sstl <= 1'b1;
			pixel_clk_off <= 1'b0;
			converter_power_on_n <= 1'b1;
			palette_ram_sel <= 1'b1;
			pixel_pll_power_n <= 1'b1;
			sys_clk_off <= 1'b0;
			core_pll_power_n <= 1'b1;
		end else begin
			device_control_reg <= in_d3 ? 3'h0 : devctl_q;
			mem_buf_sstl <= ~in_d3;
			pixel_clk_off <= in_d3;
			converter_power_on_n <= ~in_d3;
			palette_ram_sel <= ~in_d3;
			pixel_pll_power_n <= ~in_d3;
			sys_clk_off <= in_d3;
			core_pll_power_n <= ~in_d3;
		end
	end

	// ------------------------------------------------------------
	// status outputs
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			internal_reset_n <= 1'b1;
			subsys_loaded <= 1'b0;
		end else begin
			internal_reset_n <= ~irst_busy;
			subsys_loaded <= loaded_q;
		end
	end
endmodule // pci_power_rom_config_regs
`default_nettype wire

// ---- tb/cfg_regs_assertions.sv ----
// port assertions for the power, rom and subsystem config block
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_checker (
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        cfg_rd,
	input wire logic [7:0]  cfg_addr,
	input wire logic [31:0] cfg_rdata,
	input wire logic        cfg_ack,
	input wire logic        mem_req,
	input wire logic        hit_rom,
	input wire logic        hit_ctrl,
	input wire logic        hit_dma,
	input wire logic        hit_legacy_fb,
	input wire logic        hit_main_fb,
	input wire logic [2:0]  aperture_sel,
	input wire logic        mem_claim,
	input wire logic [2:0]  device_control_reg,
	input wire logic        mem_buf_sstl,
	input wire logic        pixel_clk_off,
	input wire logic        converter_power_on_n,
	input wire logic        palette_ram_sel,
	input wire logic        pixel_pll_power_n,
	input wire logic        sys_clk_off,
	input wire logic        core_pll_power_n,
	input wire logic        internal_reset_n
);
	// --------------------------------
	// low-time counter of internal reset
	// --------------------------------
	logic [5:0] low_cnt_q;
	logic       seen_d3_q;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt_q <= 6'h00;
			seen_d3_q <= 1'b0;
		end else begin
			low_cnt_q <= internal_reset_n ? 6'h00 : low_cnt_q + 6'h01;
			seen_d3_q <= seen_d3_q | sys_clk_off;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// --------------------------------
	// properties
	// --------------------------------
	property p_d3_devctl; sys_clk_off |-> device_control_reg == 3'h0; endproperty
	property p_d3_buf; sys_clk_off |-> !mem_buf_sstl; endproperty
	property p_d3_dac;
		sys_clk_off |-> pixel_clk_off && !converter_power_on_n && !palette_ram_sel
			&& !pixel_pll_power_n;
	endproperty
	property p_d3_core; core_pll_power_n == !sys_clk_off; endproperty
	property p_cap_rd; cfg_rd && cfg_addr == 8'hDC |=> cfg_ack && cfg_rdata[18:8] == 11'h100; endproperty
	property p_rom_rsvd; cfg_rd && cfg_addr == 8'h30 |=> cfg_rdata[15:1] == 15'h0000; endproperty
	property p_pm_rsvd; cfg_rd && cfg_addr == 8'hE0 |=> cfg_rdata[31:2] == 30'h00000000; endproperty
	property p_int_rst; $rose(internal_reset_n) && seen_d3_q |-> low_cnt_q == 6'h10; endproperty
	property p_no_hit;
		mem_req && !(hit_rom || hit_ctrl || hit_dma || hit_legacy_fb || hit_main_fb)
			|=> !mem_claim && aperture_sel == 3'h0;
	endproperty
	property p_ctrl_prio;
		mem_req && hit_ctrl && !hit_rom && device_control_reg[1] ##1 device_control_reg[1]
			|-> aperture_sel == 3'h2 && mem_claim;
	endproperty
	a_d3_devctl: assert property (p_d3_devctl) else $error("devctl not cleared in D3");
	a_d3_buf: assert property (p_d3_buf) else $error("buffers not switched in D3");
	a_d3_dac: assert property (p_d3_dac) else $error("palette section on in D3");
	a_d3_core: assert property (p_d3_core) else $error("core pll mismatch");
	a_cap_rd: assert property (p_cap_rd) else $error("capability header wrong");
	a_rom_rsvd: assert property (p_rom_rsvd) else $error("rom base low bits set");
	a_pm_rsvd: assert property (p_pm_rsvd) else $error("power reg high bits set");
	a_int_rst: assert property (p_int_rst) else $error("internal reset length wrong");
	a_no_hit: assert property (p_no_hit) else $error("claim without aperture");
	a_ctrl_prio: assert property (p_ctrl_prio) else $error("ctrl aperture lost");
	c_d3: cover property (sys_clk_off);
	c_int_rst: cover property ($rose(internal_reset_n) && seen_d3_q);
	c_claim: cover property (mem_claim);
endmodule // cfg_regs_checker
bind pci_power_rom_config_regs cfg_regs_checker chk_u (.sys_clk, .reset_n, .cfg_rd, .cfg_addr,
	.cfg_rdata, .cfg_ack, .mem_req, .hit_rom, .hit_ctrl, .hit_dma, .hit_legacy_fb,
	.hit_main_fb, .aperture_sel, .mem_claim, .device_control_reg, .mem_buf_sstl,
	.pixel_clk_off, .converter_power_on_n, .palette_ram_sel, .pixel_pll_power_n,
	.sys_clk_off, .core_pll_power_n, .internal_reset_n);
`default_nettype wire

// ---- tb/boot_rom_model.sv ----
// serial boot rom model, byte at address a holds a xor A5h
`timescale 1ns/1ps
`default_nettype none
module boot_rom_model (
	input  wire logic rom_cs_n,
	input  wire logic rom_sck,
	input  wire logic rom_mosi,
	output var  logic rom_miso
);
	logic [5:0]  bit_cnt;
	logic [5:0]  k;
	logic [15:0] addr;
	logic [7:0]  cur_byte;
	initial begin
		bit_cnt = 6'h00;
		addr = 16'h0000;
		rom_miso = 1'b0;
	end
	always @(negedge rom_cs_n) bit_cnt = 6'h00;
	// command then address, msb first
	always @(posedge rom_sck) if (!rom_cs_n) begin
		if (bit_cnt >= 6'h08 && bit_cnt < 6'h18) addr[6'h17 - bit_cnt] = rom_mosi;
		bit_cnt = bit_cnt + 6'h01;
	end
	// data shifted out after falling clock; released line toggles
	always @(negedge rom_sck or posedge rom_cs_n) begin
		if (rom_cs_n) rom_miso = ~rom_miso;
		else if (bit_cnt >= 6'h18) begin
			k = bit_cnt - 6'h18;
			cur_byte = (addr[7:0] + {5'h00, k[5:3]}) ^ 8'hA5;
			rom_miso = cur_byte[k[2:0]];
		end
	end
endmodule // boot_rom_model
`default_nettype wire

// ---- tb/tb_pci_power_rom_config_regs.sv ----
// self-checking bench for the config register block
`timescale 1ns/1ps
`default_nettype none
module tb_pci_power_rom_config_regs;
	logic        sys_clk, reset_n, cfg_wr, cfg_rd, cfg_ack, mem_req, strap, mem_claim;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, rd_q;
	logic [4:0]  hits;
	logic [2:0]  aperture_sel, device_control_reg;
	logic [1:0]  rom_size;
	logic        rom_cs_n, rom_sck, rom_mosi, rom_miso, mem_buf_sstl, pixel_clk_off;
	logic        converter_power_on_n, palette_ram_sel, pixel_pll_power_n, sys_clk_off;
	logic        core_pll_power_n, internal_reset_n, subsys_loaded;
	int          mismatches, checked;
	pci_power_rom_config_regs dut_u (.sys_clk, .reset_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
		.cfg_wdata, .cfg_rdata, .cfg_ack, .mem_req, .hit_rom(hits[4]), .hit_ctrl(hits[3]),
		.hit_dma(hits[2]), .hit_legacy_fb(hits[1]), .hit_main_fb(hits[0]), .aperture_sel,
		.mem_claim, .host_data_strap_line(strap), .rom_size_sel(rom_size), .rom_miso, .rom_cs_n,
		.rom_sck, .rom_mosi, .device_control_reg, .mem_buf_sstl, .pixel_clk_off,
		.converter_power_on_n, .palette_ram_sel, .pixel_pll_power_n, .sys_clk_off,
		.core_pll_power_n, .internal_reset_n, .subsys_loaded);
	boot_rom_model rom_u (.rom_cs_n, .rom_sck, .rom_mosi, .rom_miso);
	// --------------------------------
	// clock never stops
	// --------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// --------------------------------
	// shared tasks
	// --------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		cfg_wr <= wr;
		cfg_rd <= !wr;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		#1;
		n = 0;
		while (cfg_ack !== 1'b1 && n < 8) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 8) begin
			mismatches++;
			conclude;
		end
		rd_q = cfg_rdata;
	endtask
	task automatic do_reset(input logic s);
		strap <= s;
		reset_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_fixed;
		cfg(1'b1, 8'hDC, 32'hFFFFFFFF);
		cfg(1'b0, 8'hDC, 32'h0);
		cmp({21'h0, rd_q[18:8]}, 32'h00000100);
		cmp(rd_q & 32'h06000000, 32'h0);
		cfg(1'b0, 8'hE0, 32'h0);
		cmp(rd_q, 32'h0);
		cfg(1'b0, 8'h10, 32'h0);
		cmp(rd_q, 32'h0);
	endtask
	task automatic t_rom_regs(input logic s);
		cfg(1'b1, 8'h30, 32'hFFFFFFFF);
		cfg(1'b0, 8'h30, 32'h0);
		cmp(rd_q, s ? 32'hFFFF0001 : 32'h0);
	endtask
	task automatic t_subsys;
		repeat (2000) @(posedge sys_clk);
		cmp({31'h0, subsys_loaded}, 32'h1);
		cfg(1'b0, 8'h2C, 32'h0);
		cmp(rd_q, {8'h7B ^ 8'hA5, 8'h7A ^ 8'hA5, 8'h79 ^ 8'hA5, 8'h78 ^ 8'hA5});
		cfg(1'b1, 8'h2C, 32'h11111111);
		cfg(1'b0, 8'h2C, 32'h0);
		cmp(rd_q, {8'h7B ^ 8'hA5, 8'h7A ^ 8'hA5, 8'h79 ^ 8'hA5, 8'h78 ^ 8'hA5});
		cfg(1'b1, 8'h4C, 32'hCAFE1234);
		cfg(1'b0, 8'h2C, 32'h0);
		cmp(rd_q, 32'hCAFE1234);
	endtask
	task automatic t_subsys_32k;
		repeat (2000) @(posedge sys_clk);
		cfg(1'b0, 8'h2C, 32'h0);
		cmp(rd_q, {8'hFB ^ 8'hA5, 8'hFA ^ 8'hA5, 8'hF9 ^ 8'hA5, 8'hF8 ^ 8'hA5});
	endtask
	task automatic t_decode;
		logic [4:0] hv [6] = '{5'h18, 5'h0C, 5'h06, 5'h03, 5'h01, 5'h00};
		logic [2:0] ev [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
		cfg(1'b1, 8'h04, 32'h7);
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			mem_req <= 1'b1;
			hits <= hv[i];
			repeat (2) @(posedge sys_clk);
			#1;
			cmp({28'h0, aperture_sel, mem_claim}, {28'h0, ev[i], ev[i] != 3'h0});
		end
		mem_req <= 1'b0;
	endtask
	task automatic t_power;
		int cnt;
		cfg(1'b1, 8'hE0, 32'hFFFFFFFE);
		cfg(1'b0, 8'hE0, 32'h0);
		cmp(rd_q, 32'h0);
		cfg(1'b1, 8'hE0, 32'h1);
		cfg(1'b0, 8'hE0, 32'h0);
		cmp(rd_q, 32'h0);
		cfg(1'b1, 8'hE0, 32'h3);
		cfg(1'b0, 8'hE0, 32'h0);
		cmp(rd_q, 32'h3);
		cmp({22'h0, device_control_reg, mem_buf_sstl, pixel_clk_off, converter_power_on_n,
			palette_ram_sel, pixel_pll_power_n, sys_clk_off, core_pll_power_n},
			32'h00000022);
		cfg(1'b1, 8'hE0, 32'h0);
		cnt = 0;
		repeat (40) begin
			@(posedge sys_clk);
			#1;
			if (internal_reset_n === 1'b0) cnt++;
		end
		cmp(cnt, 32'h10);
		cfg(1'b0, 8'h04, 32'h0);
		cmp({rd_q[31:3], rd_q[2:0]}, 32'h0);
		cmp({31'h0, sys_clk_off}, 32'h0);
	endtask
	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		{reset_n, cfg_wr, cfg_rd, mem_req, strap} = 5'h00;
		cfg_addr = 8'h00;
		cfg_be = 4'hF;
		rom_size = 2'h0;
		cfg_wdata = 32'h0;
		hits = 5'h00;
		mismatches = 0;
		checked = 0;
		do_reset(1'b1);
		t_fixed;
		t_rom_regs(1'b1);
		t_subsys;
		t_decode;
		t_power;
		rom_size <= 2'h1;
		do_reset(1'b0);
		t_rom_regs(1'b0);
		t_subsys_32k;
		conclude;
	end
endmodule // tb_pci_power_rom_config_regs
`default_nettype wire
